// ==== rtl/sbe_host.sv ====
/*
 Host-side controller of an optical motion sensor's serial port: single
 register writes and reads, motion burst, firmware download and pixel burst.
 Assumes software on a plain register port and the sensor on its pins.
*/
`default_nettype none
`include "sbe_map.svh"
module sbe_host import sbe_pkg::*; #(
	parameter int FRAME_CYC = ((`SBE_T_FRAME_NS * `SBE_CLK_MHZ) + 999) / 1000,
	parameter int CAPTURE_CYC = (((`SBE_T_CAPTURE_EXTRA_NS + 3 * `SBE_T_FRAME_NS) * `SBE_CLK_MHZ) + 999) / 1000,
	parameter int RESYNC_CYC = ((`SBE_T_RESYNC_NS * `SBE_CLK_MHZ) + 999) / 1000,
	parameter int WAIT_W = 21
) (
	// Clock and reset
	input wire logic SYS_CLK_IN,
	input wire logic RESET_IN,
	// Software register port
	input wire logic [3:0] ADDR_IN,
	input wire logic [15:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [15:0] RDATA_OUT,
	// Sensor pins
	output logic CHIP_SELECT_N_OUT,
	output logic SCLK_OUT,
	output logic MOSI_OUT,
	input wire logic MISO_IN,
	output logic SENSOR_RESET_OUT,
	output logic POWER_DOWN_N_OUT
);
	function automatic int cyc(input int ns);
		cyc = (ns * `SBE_CLK_MHZ + 999) / 1000;
	endfunction

	localparam int HALF_CYC = cyc(`SBE_T_SCLK_HALF_NS);
	localparam logic [WAIT_W-1:0] W_WRITE = WAIT_W'(cyc(`SBE_T_WRITE_GAP_NS));
	localparam logic [WAIT_W-1:0] W_READ = WAIT_W'(cyc(`SBE_T_READ_GAP_NS));
	localparam logic [WAIT_W-1:0] W_ADDR = WAIT_W'(cyc(`SBE_T_ADDR_WAIT_NS));
	localparam logic [WAIT_W-1:0] W_MOT = WAIT_W'(cyc(`SBE_T_MOT_WAIT_NS));
	localparam logic [WAIT_W-1:0] W_EXIT = WAIT_W'(cyc(`SBE_T_BURST_EXIT_NS));
	localparam logic [WAIT_W-1:0] W_BYTE = WAIT_W'(cyc(`SBE_T_BYTE_GAP_NS));
	localparam logic [WAIT_W-1:0] W_RSTP = WAIT_W'(cyc(`SBE_T_RESET_PULSE_NS));
	localparam logic [WAIT_W-1:0] W_RSTW = WAIT_W'(cyc(`SBE_T_RESET_WAIT_NS));
	localparam logic [WAIT_W-1:0] W_FRAME = WAIT_W'(FRAME_CYC);
	localparam logic [WAIT_W-1:0] W_CAP = WAIT_W'(CAPTURE_CYC);
	localparam logic [WAIT_W-1:0] W_RESYNC = WAIT_W'(RESYNC_CYC);

	if (RESYNC_CYC >= 2 ** WAIT_W || CAPTURE_CYC >= 2 ** WAIT_W || FRAME_CYC < 1) begin : g_chk
		$error("sbe_host: wait counts do not fit WAIT_W");
	end

	// Scripted sequences: firmware download from step 0, pixel capture from step 8
	function automatic sbe_step_t step_of(input logic [3:0] s);
		unique case (s)
			// reset, then preparation writes in order
			4'h0: step_of = '{K_WRITE, `SBE_SA_PREP_A, `SBE_SV_PREP_A};
			4'h1: step_of = '{K_WRITE, `SBE_SA_PREP_B, `SBE_SV_PREP_B};
			4'h2: step_of = '{K_WRITE, `SBE_SA_PREP_C, `SBE_SV_PREP_C};
			// frame wait, load enable, open data port
			4'h3: step_of = '{K_WAIT_FRAME, 7'h00, 8'h00};
			4'h4: step_of = '{K_WRITE, `SBE_SA_FW_LOAD_CTRL, `SBE_SV_FW_ENABLE};
			4'h5: step_of = '{K_OPEN_FW, `SBE_SA_FW_DATA_PORT, 8'h00};
			// grab write, capture wait, then the image stream read
			4'h8: step_of = '{K_WRITE, `SBE_SA_IMAGE_GRAB, 8'h00};
			4'h9: step_of = '{K_WAIT_CAP, 7'h00, 8'h00};
			4'hA: step_of = '{K_OPEN_PIX, `SBE_SA_IMAGE_STREAM, 8'h00};
			default: step_of = '{K_DONE, 7'h00, 8'h00};
		endcase
	endfunction

	sbe_state_t state_ff, nxt_state;
	sbe_phase_t phase_ff, nxt_phase;
	sbe_op_t op_ff, nxt_op;
	logic [WAIT_W-1:0] wait_ff, nxt_wait, gap_ff, nxt_gap;
	logic [3:0] step_ff, nxt_step;
	logic [2:0] idx_ff, nxt_idx;
	logic cs_n_ff, nxt_cs_n, rst_pin_ff, nxt_rst_pin;
	logic [7:0] rx_ff, nxt_rx;
	logic [10:0] fwcnt_ff, nxt_fwcnt;
	logic [7:0] mot_ff [7];
	logic mot_we;
	logic pd_ff;
	logic [6:0] taddr_ff;
	logic [7:0] tdata_ff;
	logic [15:0] rdata_ff;
	logic miso_s1_ff, miso_s2_ff;
	sbe_shreq_t sh_req;
	logic sh_done;
	logic [7:0] sh_rx;
	sbe_step_t cur_step;
	sbe_step_t prev_step;

	// Software port decode
	wire cmd_go = WR_IN && (ADDR_IN == `SBE_REG_CMD);
	wire [2:0] opc = WDATA_IN[2:0];
	wire wait_done = (wait_ff == '0);
	wire gap_done = (gap_ff == '0);
	wire abort_go = cmd_go && (opc == `SBE_OP_ABORT) && (state_ff != ST_RST_HI) && (state_ff != ST_RST_LO);
	wire is_mot = (ADDR_IN >= `SBE_REG_MOT0) && (ADDR_IN <= `SBE_REG_MOT6);
	wire [2:0] mot_sel = 3'(ADDR_IN - `SBE_REG_MOT0);
	wire busy = (state_ff != ST_IDLE) && (state_ff != ST_STREAM);
	wire in_burst = !cs_n_ff && ((op_ff == OP_FW) || (op_ff == OP_PIX) || (op_ff == OP_MOT));
	wire [15:0] status = 16'({(op_ff == OP_FW), gap_done, in_burst, busy});
	assign cur_step = step_of(step_ff);
	// Step already consumed by the sequencer, source of a scripted data byte
	assign prev_step = step_of(step_ff - 4'h1);

	// Read mux; unmapped words read zero
	wire [15:0] rd_mux = (ADDR_IN == `SBE_REG_CTRL) ? 16'(pd_ff) :
		(ADDR_IN == `SBE_REG_TADDR) ? 16'(taddr_ff) :
		(ADDR_IN == `SBE_REG_TDATA) ? 16'(tdata_ff) :
		(ADDR_IN == `SBE_REG_RXDATA) ? 16'(rx_ff) :
		(ADDR_IN == `SBE_REG_STATUS) ? status :
		(ADDR_IN == `SBE_REG_FWCNT) ? 16'(fwcnt_ff) :
		is_mot ? 16'(mot_ff[mot_sel]) : 16'h0000;

	// Sequencer; single transactions park step at the done entry
	always_comb begin
		nxt_state = state_ff;
		nxt_phase = phase_ff;
		nxt_op = op_ff;
		nxt_wait = wait_done ? '0 : wait_ff - WAIT_W'(1);
		nxt_gap = gap_done ? '0 : gap_ff - WAIT_W'(1);
		nxt_step = step_ff;
		nxt_idx = idx_ff;
		nxt_cs_n = cs_n_ff;
		nxt_rst_pin = rst_pin_ff;
		nxt_rx = rx_ff;
		nxt_fwcnt = fwcnt_ff;
		mot_we = 1'b0;
		sh_req = '{1'b0, 1'b0, 8'h00};
		unique case (state_ff)
			ST_RST_HI: begin
				// sensor reset pin pulsed high, then low
				if (wait_done) begin
					nxt_rst_pin = 1'b0;
					nxt_wait = W_RSTW;
					nxt_state = ST_RST_LO;
				end
			end
			ST_RST_LO: begin
				if (wait_done)
					nxt_state = ST_SEQ;
			end
			ST_SEQ: begin
				nxt_step = step_ff + 4'h1;
				nxt_phase = PH_ADDR;
				unique case (cur_step.kind)
					K_WRITE: begin
						nxt_cs_n = 1'b0;
						nxt_op = OP_W;
						nxt_state = ST_SHIFT;
						sh_req = '{1'b1, 1'b0, {1'b1, cur_step.addr}};
					end
					K_WAIT_FRAME: begin
						nxt_wait = W_FRAME;
						nxt_state = ST_CS_UP;
					end
					K_WAIT_CAP: begin
						nxt_wait = W_CAP;
						nxt_state = ST_CS_UP;
					end
					K_OPEN_FW, K_OPEN_PIX: begin
						nxt_cs_n = 1'b0;
						nxt_op = (cur_step.kind == K_OPEN_FW) ? OP_FW : OP_PIX;
						nxt_fwcnt = 11'd0;
						nxt_state = ST_SHIFT;
						// direction bit on top of the address
						sh_req = '{1'b1, 1'b0, {(cur_step.kind == K_OPEN_FW), cur_step.addr}};
					end
					K_DONE: begin
						nxt_step = `SBE_STEP_DONE;
						nxt_state = ST_IDLE;
					end
				endcase
			end
			ST_IDLE: begin
				// Sensor ignores its serial pins while powered down
				if (cmd_go && !pd_ff) begin
					nxt_step = `SBE_STEP_DONE;
					nxt_phase = PH_ADDR;
					nxt_idx = 3'd0;
					unique case (opc)
						`SBE_OP_WRITE, `SBE_OP_READ, `SBE_OP_MOTION: begin
							nxt_cs_n = 1'b0;
							nxt_state = ST_SHIFT;
							nxt_op = (opc == `SBE_OP_WRITE) ? OP_W : (opc == `SBE_OP_READ) ? OP_R : OP_MOT;
							// write has top bit one, read zero
							sh_req.start = 1'b1;
							sh_req.tx = (opc == `SBE_OP_WRITE) ? {1'b1, taddr_ff} :
								(opc == `SBE_OP_READ) ? {1'b0, taddr_ff} : {1'b0, `SBE_SA_MOTION_STREAM};
						end
						`SBE_OP_FWLOAD: begin
							// download always starts with a hardware reset
							nxt_step = `SBE_STEP_FW;
							nxt_rst_pin = 1'b1;
							nxt_wait = W_RSTP;
							nxt_state = ST_RST_HI;
						end
						`SBE_OP_PIXEL: begin
							nxt_step = `SBE_STEP_PIX;
							nxt_state = ST_SEQ;
						end
						default: ;
					endcase
				end
			end
			ST_SHIFT: begin
				if (sh_done) begin
					unique case (phase_ff)
						PH_ADDR: begin
							if (op_ff == OP_W) begin
								nxt_phase = PH_DATA;
								sh_req = '{1'b1, 1'b0, (step_ff == `SBE_STEP_DONE) ? tdata_ff : prev_step.data};
							end else if (op_ff == OP_FW) begin
								nxt_gap = '0;
								nxt_state = ST_STREAM;
							end else begin
								// wait after the address before clocking data
								nxt_phase = (op_ff == OP_MOT) ? PH_MOT : PH_DATA;
								nxt_wait = (op_ff == OP_MOT) ? W_MOT : W_ADDR;
								nxt_state = ST_PAUSE;
							end
						end
						PH_DATA: begin
							nxt_rx = sh_rx;
							if (op_ff == OP_PIX) begin
								// first pixel by normal read, rest streamed
								nxt_gap = W_BYTE;
								nxt_state = ST_STREAM;
							end else begin
								nxt_cs_n = 1'b1;
								nxt_wait = (op_ff == OP_W) ? W_WRITE : W_READ;
								nxt_state = ST_CS_UP;
							end
						end
						PH_MOT: begin
							// bytes land in order by index
							mot_we = 1'b1;
							if (idx_ff == `SBE_MOT_BYTES - 3'd1) begin
								// burst closed by chip select high
								nxt_cs_n = 1'b1;
								nxt_wait = W_EXIT;
								nxt_state = ST_CS_UP;
							end else begin
								nxt_idx = idx_ff + 3'd1;
								sh_req = '{1'b1, 1'b0, 8'h00};
							end
						end
						PH_STREAM: begin
							nxt_rx = sh_rx;
							// count saturates at the image length
							if (op_ff == OP_FW && fwcnt_ff != `SBE_FW_IMAGE_BYTES)
								nxt_fwcnt = fwcnt_ff + 11'd1;
							// gap before the next stream byte
							nxt_gap = W_BYTE;
							nxt_state = ST_STREAM;
						end
					endcase
				end
			end
			ST_PAUSE: begin
				if (wait_done) begin
					sh_req = '{1'b1, 1'b0, 8'h00};
					nxt_state = ST_SHIFT;
				end
			end
			ST_STREAM: begin
				// only byte, end and abort orders are taken inside a burst
				if (cmd_go && opc == `SBE_OP_BYTE && gap_done) begin
					nxt_phase = PH_STREAM;
					nxt_state = ST_SHIFT;
					sh_req = '{1'b1, 1'b0, (op_ff == OP_FW) ? tdata_ff : 8'h00};
				end else if (cmd_go && opc == `SBE_OP_END) begin
					// finish with the burst exit gap
					nxt_cs_n = 1'b1;
					nxt_wait = W_EXIT;
					nxt_state = ST_CS_UP;
				end
			end
			ST_CS_UP: begin
				if (wait_done)
					nxt_state = ST_SEQ;
			end
		endcase
		// abort raises chip select for the resync time
		if (abort_go) begin
			sh_req = '{1'b0, 1'b1, 8'h00};
			nxt_cs_n = 1'b1;
			nxt_wait = W_RESYNC;
			nxt_step = `SBE_STEP_DONE;
			nxt_state = ST_CS_UP;
		end
	end

	// State registers; power-up enters the reset pulse
	always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			state_ff <= ST_RST_HI;
			phase_ff <= PH_ADDR;
			op_ff <= OP_W;
			wait_ff <= W_RSTP;
			gap_ff <= '0;
			step_ff <= `SBE_STEP_DONE;
			idx_ff <= 3'd0;
			cs_n_ff <= 1'b1;
			rst_pin_ff <= 1'b1;
			rx_ff <= 8'h00;
			fwcnt_ff <= 11'd0;
		end else begin
			state_ff <= nxt_state;
			phase_ff <= nxt_phase;
			op_ff <= nxt_op;
			wait_ff <= nxt_wait;
			gap_ff <= nxt_gap;
			step_ff <= nxt_step;
			idx_ff <= nxt_idx;
			cs_n_ff <= nxt_cs_n;
			rst_pin_ff <= nxt_rst_pin;
			rx_ff <= nxt_rx;
			fwcnt_ff <= nxt_fwcnt;
		end
	end

	// Motion burst bytes; no reset needed on this storage
	always_ff @(posedge SYS_CLK_IN) begin
		if (mot_we)
			mot_ff[idx_ff] <= sh_rx;
	end

	// Software-written registers and read data valid one cycle
	always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			pd_ff <= `SBE_CTRL_RESET;
			taddr_ff <= 7'h00;
			tdata_ff <= 8'h00;
			rdata_ff <= 16'h0000;
		end else begin
			if (WR_IN && ADDR_IN == `SBE_REG_CTRL)
				pd_ff <= WDATA_IN[`SBE_CTRL_PD_BIT];
			if (WR_IN && ADDR_IN == `SBE_REG_TADDR)
				taddr_ff <= WDATA_IN[6:0];
			if (WR_IN && ADDR_IN == `SBE_REG_TDATA)
				tdata_ff <= WDATA_IN[7:0];
			rdata_ff <= RD_IN ? rd_mux : 16'h0000;
		end
	end

	// Sensor output is a foreign domain: two flops before use
	always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			miso_s1_ff <= 1'b0;
			miso_s2_ff <= 1'b0;
		end else begin
			miso_s1_ff <= MISO_IN;
			miso_s2_ff <= miso_s1_ff;
		end
	end

	// master samples on rising, changes on falling
	sbe_shift #(.HALF_CYC(HALF_CYC)) u_shift (
		.clk_in(SYS_CLK_IN),
		.rst_in(RESET_IN),
		.req_in(sh_req),
		.miso_in(miso_s2_ff),
		.done_out(sh_done),
		.rx_out(sh_rx),
		.sclk_out(SCLK_OUT),
		.mosi_out(MOSI_OUT)
	);

	assign RDATA_OUT = rdata_ff;
	assign CHIP_SELECT_N_OUT = cs_n_ff;
	assign SENSOR_RESET_OUT = rst_pin_ff;
	// power-down level straight from software control
	assign POWER_DOWN_N_OUT = !pd_ff;
endmodule
`default_nettype wire

// ==== rtl/sbe_map.svh ====
/*
 Offsets, field positions, opcodes, sensor addresses and timing figures of the
 serial burst engine controller. Assumes a 20 MHz system clock.
*/
`ifndef SBE_MAP_SVH
`define SBE_MAP_SVH

// System clock rate
`define SBE_CLK_MHZ 20

// Software register indexes (word index on the plain port)
`define SBE_REG_CTRL 4'h0
`define SBE_REG_CMD 4'h1
`define SBE_REG_TADDR 4'h2
`define SBE_REG_TDATA 4'h3
`define SBE_REG_RXDATA 4'h4
`define SBE_REG_STATUS 4'h5
`define SBE_REG_FWCNT 4'h6
`define SBE_REG_MOT0 4'h8
`define SBE_REG_MOT6 4'hE

// Field positions
`define SBE_CTRL_PD_BIT 0
`define SBE_ST_BUSY_BIT 0
`define SBE_ST_BURST_BIT 1
`define SBE_ST_GAPOK_BIT 2
`define SBE_ST_FWMODE_BIT 3
`define SBE_CTRL_RESET 1'b0

// Command opcodes (low three bits of a CMD write)
`define SBE_OP_ABORT 3'h0
`define SBE_OP_WRITE 3'h1
`define SBE_OP_READ 3'h2
`define SBE_OP_MOTION 3'h3
`define SBE_OP_FWLOAD 3'h4
`define SBE_OP_PIXEL 3'h5
`define SBE_OP_BYTE 3'h6
`define SBE_OP_END 3'h7

// Sensor addresses and values
`define SBE_SA_MOTION_STREAM 7'h50
`define SBE_SA_IMAGE_STREAM 7'h40
`define SBE_SA_IMAGE_GRAB 7'h13
`define SBE_SA_FW_LOAD_CTRL 7'h14
`define SBE_SA_FW_DATA_PORT 7'h60
`define SBE_SA_PREP_A 7'h20
`define SBE_SA_PREP_B 7'h23
`define SBE_SA_PREP_C 7'h24
`define SBE_SV_PREP_A 8'h44
`define SBE_SV_PREP_B 8'h07
`define SBE_SV_PREP_C 8'h88
`define SBE_SV_FW_ENABLE 8'h18
`define SBE_FW_IMAGE_BYTES 11'd1986
`define SBE_MOT_BYTES 3'd7

// Step table entry points
`define SBE_STEP_FW 4'h0
`define SBE_STEP_PIX 4'h8
`define SBE_STEP_DONE 4'hF

// Times in ns
`define SBE_T_SCLK_HALF_NS 250
`define SBE_T_WRITE_GAP_NS 50000
`define SBE_T_READ_GAP_NS 250
`define SBE_T_ADDR_WAIT_NS 50000
`define SBE_T_MOT_WAIT_NS 75000
`define SBE_T_BURST_EXIT_NS 4000
`define SBE_T_BYTE_GAP_NS 10000
`define SBE_T_RESET_PULSE_NS 10000
`define SBE_T_RESET_WAIT_NS 50000
`define SBE_T_FRAME_NS 500000
`define SBE_T_CAPTURE_EXTRA_NS 10000
`define SBE_T_RESYNC_NS 1000000

`endif

// ==== rtl/sbe_pkg.sv ====
/*
 Types of the serial burst engine controller.
 Assumes sbe_map.svh for the numeric constants.
*/
`default_nettype none
package sbe_pkg;
	typedef enum logic [3:0] {ST_RST_HI, ST_RST_LO, ST_SEQ, ST_IDLE, ST_SHIFT, ST_PAUSE, ST_STREAM,
		ST_CS_UP} sbe_state_t;
	typedef enum logic [1:0] {PH_ADDR, PH_DATA, PH_MOT, PH_STREAM} sbe_phase_t;
	typedef enum logic [2:0] {OP_W, OP_R, OP_MOT, OP_FW, OP_PIX} sbe_op_t;
	typedef enum logic [2:0] {K_WRITE, K_WAIT_FRAME, K_WAIT_CAP, K_OPEN_FW, K_OPEN_PIX, K_DONE} sbe_kind_t;
	// One step of a scripted sequence
	typedef struct packed {
		sbe_kind_t kind;
		logic [6:0] addr;
		logic [7:0] data;
	} sbe_step_t;
	// Request to the byte shifter
	typedef struct packed {
		logic start;
		logic abort;
		logic [7:0] tx;
	} sbe_shreq_t;
endpackage
`default_nettype wire

// ==== rtl/sbe_shift.sv ====
/*
 Byte shifter of the serial master: SCLK idles high, data changes on falling
 edges and the slave output is sampled on rising edges, MSB first.
 Assumes a synchronised miso input and a one-cycle start pulse.
*/
`default_nettype none
module sbe_shift import sbe_pkg::*; #(
	parameter int HALF_CYC = 5
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Request and answer
	input wire sbe_shreq_t req_in,
	input wire logic miso_in,
	output logic done_out,
	output logic [7:0] rx_out,
	// Serial pins
	output logic sclk_out,
	output logic mosi_out
);
	localparam int CW = $clog2(HALF_CYC + 1);
	if (HALF_CYC < 1) begin : g_chk
		$error("sbe_shift: HALF_CYC must be at least 1");
	end

	logic [CW-1:0] cnt_ff;
	logic [3:0] left_ff;
	logic busy_ff;
	logic [7:0] sh_ff;
	wire tick = busy_ff && (cnt_ff == CW'(HALF_CYC - 1));
	wire fall = tick && sclk_out && (left_ff != 4'h0);
	wire rise = tick && !sclk_out;
	wire fin = tick && sclk_out && (left_ff == 4'h0);

	// Half-period timer; a start first holds SCLK high for a setup half period
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_ff <= '0;
			busy_ff <= 1'b0;
			left_ff <= 4'h0;
		end else if (req_in.abort) begin
			busy_ff <= 1'b0;
			cnt_ff <= '0;
		end else if (req_in.start) begin
			busy_ff <= 1'b1;
			cnt_ff <= '0;
			left_ff <= 4'h8;
		end else if (busy_ff) begin
			cnt_ff <= tick ? '0 : cnt_ff + CW'(1);
			busy_ff <= !fin;
			if (fall)
				left_ff <= left_ff - 4'h1;
		end
	end

	// Pins: shift out on falling edge, sample in on rising edge
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sclk_out <= 1'b1;
			mosi_out <= 1'b1;
			sh_ff <= 8'h00;
			rx_out <= 8'h00;
			done_out <= 1'b0;
		end else begin
			done_out <= fin && !req_in.abort;
			if (req_in.abort) begin
				sclk_out <= 1'b1;
			end else if (req_in.start) begin
				sh_ff <= req_in.tx;
			end else if (fall) begin
				sclk_out <= 1'b0;
				mosi_out <= sh_ff[7];
				sh_ff <= {sh_ff[6:0], 1'b0};
			end else if (rise) begin
				sclk_out <= 1'b1;
				rx_out <= {rx_out[6:0], miso_in};
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/sbe_host_sva.sv ====
/* Checker of the serial pins of sbe_host.
 Assumes a bind to sbe_host; sees its ports only. */
`default_nettype none
module sbe_host_sva (
	// Clock and reset
	input wire logic SYS_CLK_IN,
	input wire logic RESET_IN,
	// Sensor pins
	input wire logic CHIP_SELECT_N_OUT,
	input wire logic SCLK_OUT,
	input wire logic MOSI_OUT,
	input wire logic SENSOR_RESET_OUT
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (RESET_IN);
	logic [15:0] rst_hi_ff;
	logic [15:0] cs_hi_ff;
	// High-time counters; chip select saturates so a long idle never wraps
	always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			rst_hi_ff <= 16'h0000;
			cs_hi_ff <= 16'h0000;
		end else begin
			rst_hi_ff <= SENSOR_RESET_OUT ? rst_hi_ff + 16'h0001 : 16'h0000;
			cs_hi_ff <= CHIP_SELECT_N_OUT ? cs_hi_ff + {15'h0000, ~&cs_hi_ff} : 16'h0000;
		end
	end
	// Bit cell halves; an abort may cut the low half short
	sequence s_low_half;
		!SCLK_OUT [*5] ##1 SCLK_OUT;
	endsequence
	sequence s_high_half;
		SCLK_OUT [*5];
	endsequence
	a_sclk_low: assert property ($fell(SCLK_OUT) |-> s_low_half or (!SCLK_OUT ##[0:4] CHIP_SELECT_N_OUT))
		else $error("SCLK low half wrong");
	a_sclk_high: assert property ($rose(SCLK_OUT) |-> s_high_half)
		else $error("SCLK high half short");
	a_mosi_hold: assert property ($rose(SCLK_OUT) |-> ($stable(MOSI_OUT) || CHIP_SELECT_N_OUT) [*5])
		else $error("MOSI moved while SCLK high");
	a_cs_setup: assert property ($fell(CHIP_SELECT_N_OUT) |-> s_high_half)
		else $error("SCLK fell too soon after select");
	a_cs_clk_idle: assert property (CHIP_SELECT_N_OUT |-> SCLK_OUT)
		else $error("SCLK active while deselected");
	a_cs_gap: assert property ($fell(CHIP_SELECT_N_OUT) |-> cs_hi_ff >= 16'h0004)
		else $error("Chip select gap too short");
	a_rst_pulse: assert property ($fell(SENSOR_RESET_OUT) |-> rst_hi_ff >= 16'h00C7)
		else $error("Sensor reset pulse too short");
	a_rst_quiet: assert property (SENSOR_RESET_OUT |-> CHIP_SELECT_N_OUT)
		else $error("Sensor selected during reset");
endmodule
bind sbe_host sbe_host_sva i_sva (.SYS_CLK_IN(SYS_CLK_IN), .RESET_IN(RESET_IN),
	.CHIP_SELECT_N_OUT(CHIP_SELECT_N_OUT), .SCLK_OUT(SCLK_OUT), .MOSI_OUT(MOSI_OUT),
	.SENSOR_RESET_OUT(SENSOR_RESET_OUT));
`default_nettype wire

// ==== tb/sbe_sensor_model.sv ====
/* Behavioural model of the sensor serial port and burst modes.
 Assumes a master that keeps chip select high between frames. */
`default_nettype none
module sbe_sensor_model #(
	parameter int GAP_NS = 10000
) (
	// Serial port
	input wire logic cs_n_in,
	input wire logic sclk_in,
	input wire logic mosi_in,
	output logic miso_out,
	// Control pins
	input wire logic rst_in,
	input wire logic pd_n_in,
	output logic illum_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] rf [0:127];
	logic [7:0] ib = 8'h00;
	logic [7:0] ob = 8'h00;
	logic [7:0] a = 8'h00;
	logic q = 1'b0;
	logic trk = 1'b1;
	logic fw_en = 1'b0;
	logic grab = 1'b0;
	logic act;
	int bc = 0;
	int idx = 0;
	int mode = 0;
	int ps = 0;
	int fw_n = 0;
	int err = 0;
	realtime t_last = 0.0;
	// pins ignored in reset, power-down or deselect
	assign act = !cs_n_in && !rst_in && pd_n_in;
	function automatic logic [7:0] nxt();
		case (mode)
			2: return (a[6:0] inside {7'h0A, 7'h13}) ? rf[a[6:0]] : 8'h00;
			3: return (trk && idx < 7) ? 8'hA1 + idx[7:0] : 8'h00;
			4: return (!grab || idx >= 1536) ? 8'h00 : {1'b1, idx == 0 || idx == 900, idx[5:0]};
			default: return 8'h00;
		endcase
	endfunction
	// write effects; preparation order is tracked
	task automatic put(input logic [6:0] ad, input logic [7:0] d);
		if (ad inside {7'h0A, 7'h13})
			rf[ad] = d;
		if (ad == 7'h13) begin
			trk = 1'b0;
			fw_en = 1'b0;
			grab = 1'b1;
		end
		if (ad inside {7'h20, 7'h23, 7'h24})
			ps = ({ad, d, ps[1:0]} inside {17'h08110, 17'h08C1D, 17'h09222}) ? ps + 1 : 0;
		if (ad == 7'h14)
			fw_en = d == 8'h18 && ps == 3;
	endtask
	task automatic got(input logic [7:0] b);
		case (mode)
			0: begin
				a = b;
				idx = 0;
				mode = b[7] ? ((b[6:0] == 7'h60 && fw_en) ? 5 : 1) : (b == 8'h50) ? 3 : (b == 8'h40) ? 4 : 2;
				// Address is no image byte, so the first image byte owes it no gap
				t_last = $realtime - GAP_NS;
			end
			1: begin
				put(a[6:0], b);
				mode = 6;
			end
			5: begin
				err += ($realtime - t_last < GAP_NS) ? 1 : 0;
				t_last = $realtime;
				fw_n += (fw_n < 1986) ? 1 : 0;
			end
			default: idx++;
		endcase
		ob = nxt();
	endtask
	always @(posedge sclk_in) begin
		if (act) begin
			ib = {ib[6:0], mosi_in};
			bc++;
			if (bc == 8) begin
				bc = 0;
				got(ib);
			end
		end
	end
	always @(negedge sclk_in) begin
		if (act) begin
			q = ob[7];
			ob = {ob[6:0], 1'b0};
		end
	end
	// deselect clears the port, registers kept
	always @(posedge cs_n_in) begin
		bc = 0;
		idx = 0;
		mode = 0;
	end
	always @(posedge rst_in) begin
		trk = 1'b1;
		fw_en = 1'b0;
		grab = 1'b0;
		ps = 0;
		fw_n = 0;
	end
	// Released data line shows the inverse of the last bit
	assign miso_out = cs_n_in ? ~q : q;
	assign illum_out = !rst_in && pd_n_in;
endmodule
`default_nettype wire

// ==== tb/sbe_host_tb.sv ====
/* Self-checking bench of the serial burst engine controller.
 Assumes sbe_sensor_model on the far side and the bound checker. */
`default_nettype none
`include "sbe_map.svh"
module sbe_host_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] rdata;
	logic cs_n;
	logic sclk;
	logic mosi;
	logic miso;
	logic srst;
	logic pd_n;
	int n_fail = 0;
	int checks = 0;
	// 20 MHz clock
	always #25 clk = ~clk;
	// Short frame, capture and resync waits keep the run brief
	sbe_host #(.FRAME_CYC(50), .CAPTURE_CYC(200), .RESYNC_CYC(100)) i_dut (.SYS_CLK_IN(clk), .RESET_IN(rst),
		.ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .CHIP_SELECT_N_OUT(cs_n),
		.SCLK_OUT(sclk), .MOSI_OUT(mosi), .MISO_IN(miso), .SENSOR_RESET_OUT(srst), .POWER_DOWN_N_OUT(pd_n));
	sbe_sensor_model i_sen (.cs_n_in(cs_n), .sclk_in(sclk), .mosi_in(mosi), .miso_out(miso), .rst_in(srst),
		.pd_n_in(pd_n), .illum_out());
	// Verdict
	task automatic stop_test();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic lost();
		n_fail++;
		$display("[FAIL] %0t wait timed out", $time);
		stop_test();
	endtask
	// Plain port cycles
	task automatic wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask
	task automatic cmd(input logic [2:0] op);
		wreg(`SBE_REG_CMD, {13'h0000, op});
	endtask
	// Poll one status bit, bounded
	task automatic wt(input int b, input logic v);
		for (int i = 0; i < 30000; i++) begin
			@(posedge clk);
			addr <= `SBE_REG_STATUS;
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			#1;
			if (rdata[b] === v)
				return;
		end
		lost();
	endtask
	task automatic upto(input int m, input int k);
		for (int i = 0; i < 20000; i++) begin
			@(posedge clk);
			if (i_sen.mode == m && i_sen.idx >= k)
				return;
		end
		lost();
	endtask
	task automatic sacc(input logic [2:0] op, input logic [15:0] ta, input logic [15:0] td);
		wreg(`SBE_REG_TADDR, ta);
		wreg(`SBE_REG_TDATA, td);
		cmd(op);
		wt(`SBE_ST_BUSY_BIT, 1'b0);
	endtask
	task automatic nbyte();
		wt(`SBE_ST_GAPOK_BIT, 1'b1);
		cmd(`SBE_OP_BYTE);
		wt(`SBE_ST_GAPOK_BIT, 1'b0);
		wt(`SBE_ST_GAPOK_BIT, 1'b1);
	endtask
	// Software registers, unmapped word, refusal in power-down
	task automatic t_regs();
		wt(`SBE_ST_BUSY_BIT, 1'b0);
		rchk(`SBE_REG_CTRL, 16'h0000);
		wreg(4'h7, 16'hFFFF);
		rchk(4'h7, 16'h0000);
		wreg(`SBE_REG_CTRL, 16'h0001);
		cmd(`SBE_OP_READ);
		repeat (10) @(posedge clk);
		chk({14'h0000, pd_n, cs_n}, 16'h0001);
		wreg(`SBE_REG_CTRL, 16'h0000);
	endtask
	// Single writes and reads, implemented and not
	task automatic t_rw();
		sacc(`SBE_OP_WRITE, 16'h000A, 16'h005A);
		chk({8'h00, i_sen.rf[10]}, 16'h005A);
		sacc(`SBE_OP_WRITE, 16'h003E, 16'h0077);
		sacc(`SBE_OP_READ, 16'h003E, 16'h0000);
		rchk(`SBE_REG_RXDATA, 16'h0000);
		sacc(`SBE_OP_READ, 16'h000A, 16'h0000);
		rchk(`SBE_REG_RXDATA, 16'h005A);
	endtask
	// Abort in the middle of the data byte
	task automatic t_abort();
		wreg(`SBE_REG_TDATA, 16'h0011);
		cmd(`SBE_OP_WRITE);
		repeat (120) @(posedge clk);
		cmd(`SBE_OP_ABORT);
		wt(`SBE_ST_BUSY_BIT, 1'b0);
		chk({8'h00, i_sen.rf[10]}, 16'h005A);
	endtask
	task automatic t_mot(input logic on);
		cmd(`SBE_OP_MOTION);
		wt(`SBE_ST_BUSY_BIT, 1'b0);
		for (int i = 0; i < 7; i++)
			rchk(4'(`SBE_REG_MOT0 + i), on ? 16'h00A1 + 16'(i) : 16'h0000);
	endtask
	// Download with a refused order inside the burst
	task automatic t_fw();
		cmd(`SBE_OP_FWLOAD);
		upto(5, 0);
		for (int i = 0; i < 3; i++) begin
			wreg(`SBE_REG_TDATA, 16'h00C0 + 16'(i));
			nbyte();
		end
		cmd(`SBE_OP_READ);
		rchk(`SBE_REG_STATUS, 16'h000E);
		cmd(`SBE_OP_END);
		wt(`SBE_ST_BUSY_BIT, 1'b0);
		chk({15'h0000, i_sen.fw_en}, 16'h0001);
		chk(16'(i_sen.fw_n), 16'h0003);
		chk(16'(i_sen.err), 16'h0000);
		rchk(`SBE_REG_FWCNT, 16'h0003);
	endtask
	// Pixel capture, three bytes, then abort
	task automatic t_pix();
		cmd(`SBE_OP_PIXEL);
		upto(4, 1);
		wt(`SBE_ST_GAPOK_BIT, 1'b0);
		wt(`SBE_ST_GAPOK_BIT, 1'b1);
		rchk(`SBE_REG_STATUS, 16'h0006);
		rchk(`SBE_REG_RXDATA, 16'h00C0);
		for (int i = 1; i < 3; i++) begin
			nbyte();
			rchk(`SBE_REG_RXDATA, 16'h0080 + 16'(i));
		end
		cmd(`SBE_OP_ABORT);
		wt(`SBE_ST_BUSY_BIT, 1'b0);
		chk({15'h0000, i_sen.trk}, 16'h0000);
	endtask
	// Main sequence
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_rw();
		t_abort();
		t_mot(1'b1);
		t_fw();
		t_pix();
		t_mot(1'b0);
		stop_test();
	end
endmodule
`default_nettype wire
